// ==== afesl_ctrl.sv ====
// slot sequencer, input routing, led drive control and axi4-lite registers
//
// Added by the designer: register access over AXI4-Lite and the address map.
module afesl_ctrl
  import afesl_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  ce,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  adc_done,
  output logic                       adc_start,
  output logic                       adc_chan,
  output logic                       buf_wr,
  output logic                       buf_chan,
  output logic [3:0]                 slot_index,
  output logic                       ch2_power,
  output logic                       precon_active,
  output afesl_pkg::afesl_precon_e   precon_sel,
  output afesl_pkg::afesl_pair_s [3:0] pair_ctl,
  output afesl_pkg::afesl_led_s      led_ctl
);
  import afesl_pkg::*;

  logic                 run_r;
  logic [3:0]           diff_r;
  logic [3:0][1:0]      idle_r;
  logic [31:0]          w0_r [NUM_SLOTS];
  logic [31:0]          w1_r [NUM_SLOTS];
  logic [31:0]          w2_r [NUM_SLOTS];
  afesl_state_e         state_r;
  afesl_state_e         state_nxt;
  logic [3:0]           slot_r;
  logic [15:0]          cnt_r;
  afesl_slot_s          cur_r;
  afesl_slot_s          cfg_nxt;
  logic [3:0][7:0]      grant_r;
  logic [3:0][7:0]      grant_nxt;
  logic                 ch2_act;
  logic                 adc_start_r;
  logic                 adc_chan_r;
  logic                 aw_hold_r;
  logic                 w_hold_r;
  logic [11:0]          awaddr_r;
  logic [31:0]          wdata_r;
  logic [3:0]           wstrb_r;
  logic                 bvalid_r;
  logic [1:0]           bresp_r;
  logic                 rvalid_r;
  logic [1:0]           rresp_r;
  logic [31:0]          rdata_r;
  logic [31:0]          rd_word;
  logic                 rd_hit;
  logic [31:0]          wmask;
  logic [3:0]           wr_slot;

  // current code to milliamps, flat above the driver ceiling
  function automatic logic [8:0] code_ma(input logic [6:0] code);
    logic [8:0] ma;
    ma = 9'h000;
    if (code == 7'h00)
      ma = 9'h000;
    else if (code < STEP_KNEE)
      ma = {2'b00, code} + 9'h001;
    else
      ma = 9'h010 + {1'b0, code - 7'h0F, 1'b0};
    if (ma > DRIVER_MAX_MA)
      ma = DRIVER_MAX_MA;
    return ma;
  endfunction

  function automatic logic [15:0] us_cycles(input logic [7:0] us);
    logic [15:0] c;
    c = 16'(us) * 16'(CYC_PER_US);
    return (c == 16'h0000) ? 16'h0000 : c - 16'h0001;
  endfunction

  // unpack the upcoming slot words
  always_comb
  begin
    cfg_nxt.route   = w0_r[slot_r][W0_ROUTE_LSB +: 16];
    cfg_nxt.precon  = w0_r[slot_r][W0_PRECON_LSB +: 3];
    cfg_nxt.ch2_en  = w0_r[slot_r][W0_CH2_BIT];
    cfg_nxt.mode    = afesl_mode_e'(w0_r[slot_r][W0_MODE_LSB +: 2]);
    cfg_nxt.slot_en = w0_r[slot_r][W0_SLOTEN_BIT];
    cfg_nxt.pre_w   = w0_r[slot_r][W0_PREW_LSB +: 8];
    cfg_nxt.sides   = w2_r[slot_r][W2_SIDE_LSB +: 4];
    cfg_nxt.pulse_w = w2_r[slot_r][W2_PULSEW_LSB +: 8];
    for (int i = 0; i < NUM_DRV; i++)
      cfg_nxt.level[i] = w1_r[slot_r][8*i +: 7];
  end

  always_comb
  begin
    logic [8:0] left;
    logic [8:0] req;
    left = TOTAL_LIMIT_MA;
    req  = 9'h000;
    for (int i = 0; i < NUM_DRV; i++)
    begin
      req = code_ma(cfg_nxt.level[i]);
      if (req > left)
        req = left;
      grant_nxt[i] = req[7:0];
      left = left - req;
    end
  end

  assign ch2_act = cur_r.ch2_en && (cur_r.mode == MODE_STANDARD);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (run_r)
          state_nxt = !cfg_nxt.slot_en ? ST_NEXT :
                      (cfg_nxt.pre_w == 8'h00) ? ST_PULSE : ST_PRE;
      ST_PRE:
        if (cnt_r == 16'h0000)
          state_nxt = ST_PULSE;
      ST_PULSE:
        if (cnt_r == 16'h0000)
          state_nxt = ST_CONV1;
      ST_CONV1:
        if (adc_done && !adc_start_r)
          state_nxt = ch2_act ? ST_CONV2 : ST_WR1;
      ST_CONV2:
        if (adc_done && !adc_start_r)
          state_nxt = ST_WR1;
      ST_WR1:
        state_nxt = ch2_act ? ST_WR2 : ST_NEXT;
      ST_WR2:
        state_nxt = ST_NEXT;
      ST_NEXT:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state_r <= ST_IDLE;
    else if (ce)
      state_r <= state_nxt;
  end

  // slot walk, wraps after the last slot
  always_ff @(posedge clk)
  begin
    if (reset)
      slot_r <= 4'h0;
    else if (ce && state_r == ST_NEXT)
      slot_r <= (slot_r == 4'(NUM_SLOTS - 1)) ? 4'h0 : slot_r + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cur_r   <= '0;
      grant_r <= '0;
    end
    else if (ce && state_r == ST_IDLE && run_r)
    begin
      cur_r   <= cfg_nxt;
      grant_r <= grant_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_r <= 16'h0000;
    else if (ce)
    begin
      if (state_r == ST_IDLE)
        cnt_r <= (cfg_nxt.pre_w == 8'h00) ? us_cycles(cfg_nxt.pulse_w)
                                          : us_cycles(cfg_nxt.pre_w);
      else if (state_r == ST_PRE && cnt_r == 16'h0000)
        cnt_r <= us_cycles(cur_r.pulse_w);
      else if (cnt_r != 16'h0000)
        cnt_r <= cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      adc_start_r <= 1'b0;
      adc_chan_r  <= 1'b0;
    end
    else if (ce)
    begin
      adc_start_r <= (state_nxt == ST_CONV1 && state_r != ST_CONV1) ||
                     (state_nxt == ST_CONV2 && state_r != ST_CONV2);
      if (state_nxt == ST_CONV1)
        adc_chan_r <= 1'b0;
      else if (state_nxt == ST_CONV2)
        adc_chan_r <= 1'b1;
    end
  end

  assign adc_start = adc_start_r;
  assign adc_chan  = adc_chan_r;
  assign buf_wr    = ce && (state_r == ST_WR1 || state_r == ST_WR2);
  assign buf_chan  = (state_r == ST_WR2);
  assign slot_index = slot_r;
  // second channel powered in its slot
  assign ch2_power = ch2_act && state_r != ST_IDLE && state_r != ST_NEXT;
  assign precon_active = (state_r == ST_PRE);
  assign precon_sel    = afesl_precon_e'(cur_r.precon);

  always_comb
  begin
    for (int p = 0; p < NUM_PAIRS; p++)
    begin
      pair_ctl[p].active = (state_r == ST_PRE || state_r == ST_PULSE) &&
                           (cur_r.route[p] != 4'h0);
      pair_ctl[p].diff   = diff_r[p];
      pair_ctl[p].route  = cur_r.route[p];
      pair_ctl[p].idle   = idle_r[p];
    end
  end

  // one side per driver, code zero off
  always_comb
  begin
    for (int d = 0; d < NUM_DRV; d++)
    begin
      led_ctl.side_a_en[d] = (state_r == ST_PULSE) && (grant_r[d] != 8'h00) &&
                             !cur_r.sides[d];
      led_ctl.side_b_en[d] = (state_r == ST_PULSE) && (grant_r[d] != 8'h00) &&
                             cur_r.sides[d];
    end
    led_ctl.grant_ma = grant_r;
  end

  // axi write side, address and data taken in either order
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  function automatic logic slot_hit(input logic [11:0] a);
    return (a >= ADDR_SLOT_BASE) && (a < ADDR_SLOT_END) && (a[1:0] == 2'h0) &&
           (a[3:2] < 2'(SLOT_WORDS));
  endfunction

  always_comb
  begin
    for (int b = 0; b < 4; b++)
      wmask[8*b +: 8] = {8{wstrb_r[b]}};
  end

  assign wr_slot = awaddr_r[7:4];

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 12'h000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (aw_hold_r && w_hold_r)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (awaddr_r == ADDR_GLOBAL || awaddr_r == ADDR_STATUS ||
                      slot_hit(awaddr_r)) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      run_r  <= 1'b0;
      diff_r <= 4'h0;
      idle_r <= '0;
    end
    else if (ce && aw_hold_r && w_hold_r && awaddr_r == ADDR_GLOBAL)
    begin
      if (wstrb_r[0])
      begin
        run_r  <= wdata_r[G_RUN_BIT];
        diff_r <= wdata_r[G_DIFF_LSB +: 4];
      end
      if (wstrb_r[1])
        idle_r <= wdata_r[G_IDLE_LSB +: 8];
    end
  end

  // slot words may change mid-slot; the running slot keeps its latched copy
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < NUM_SLOTS; i++)
      begin
        w0_r[i] <= W0_RST;
        w1_r[i] <= 32'h0000_0000;
        w2_r[i] <= W2_RST;
      end
    end
    else if (ce && aw_hold_r && w_hold_r && slot_hit(awaddr_r))
    begin
      case (awaddr_r[3:2])
        2'h0:    w0_r[wr_slot] <= (w0_r[wr_slot] & ~wmask) | (wdata_r & wmask);
        2'h1:    w1_r[wr_slot] <= (w1_r[wr_slot] & ~wmask) | (wdata_r & wmask);
        2'h2:    w2_r[wr_slot] <= (w2_r[wr_slot] & ~wmask) | (wdata_r & wmask);
        default: w2_r[wr_slot] <= w2_r[wr_slot];
      endcase
    end
  end

  // axi read side
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_comb
  begin
    logic [3:0] s;
    s = s_axi_araddr[7:4];
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (s_axi_araddr == ADDR_GLOBAL)
      rd_word = {16'h0000, idle_r, diff_r, 3'h0, run_r};
    else if (s_axi_araddr == ADDR_STATUS)
      rd_word = {20'h00000, 1'b0, state_r, 4'h0, slot_r};
    else if (slot_hit(s_axi_araddr))
    begin
      case (s_axi_araddr[3:2])
        2'h0:    rd_word = w0_r[s] & 32'hFF7F_FFFF;
        2'h1:    rd_word = w1_r[s] & 32'h7F7F_7F7F;
        default: rd_word = w2_r[s] & 32'h0000_FF0F;
      endcase
    end
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && !rvalid_r)
      begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_word;
        rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready)
        rvalid_r <= 1'b0;
    end
  end

  // checking helpers
  logic [15:0] pre_len_h;
  always_ff @(posedge clk)
  begin
    if (reset)
      pre_len_h <= 16'h0000;
    else if (ce)
      pre_len_h <= (state_r == ST_PRE) ? pre_len_h + 16'h0001 : 16'h0000;
  end

  sequence s_wr_first;
    ce && state_r == ST_WR1 && ch2_act;
  endsequence
  sequence s_slot_last;
    ce && state_r == ST_NEXT && slot_r == 4'(NUM_SLOTS - 1);
  endsequence

  property p_one_side;
    @(posedge clk) disable iff (reset)
    (led_ctl.side_a_en & led_ctl.side_b_en) == 4'h0;
  endproperty
  a_one_side: assert property (p_one_side) else $error("both sides of a driver on");

  property p_total_limit;
    @(posedge clk) disable iff (reset)
    (10'(grant_r[0]) + 10'(grant_r[1]) + 10'(grant_r[2]) + 10'(grant_r[3])) <=
      10'(TOTAL_LIMIT_MA);
  endproperty
  a_total_limit: assert property (p_total_limit) else $error("slot current over limit");

  property p_first_priority;
    @(posedge clk) disable iff (reset)
    (state_r == ST_PULSE) |-> 9'(grant_r[0]) == code_ma(cur_r.level[0]);
  endproperty
  a_first_priority: assert property (p_first_priority) else $error("driver one cut");

  property p_ch2_quiet;
    @(posedge clk) disable iff (reset)
    (adc_start_r && adc_chan_r) |-> ch2_act && $past(state_r) == ST_CONV1;
  endproperty
  a_ch2_quiet: assert property (p_ch2_quiet) else $error("channel two converted");

  property p_wr_order;
    @(posedge clk) disable iff (reset)
    s_wr_first |=> state_r == ST_WR2 && buf_chan;
  endproperty
  a_wr_order: assert property (p_wr_order) else $error("channel two not after one");

  property p_pre_len;
    @(posedge clk) disable iff (reset)
    (state_r == ST_PULSE && $past(state_r) == ST_PRE) |->
      pre_len_h == 16'(cur_r.pre_w) * 16'(CYC_PER_US);
  endproperty
  a_pre_len: assert property (p_pre_len) else $error("precondition length wrong");

  property p_inputs_idle;
    @(posedge clk) disable iff (reset)
    !(state_r == ST_PRE || state_r == ST_PULSE) |->
      !(pair_ctl[0].active || pair_ctl[1].active || pair_ctl[2].active || pair_ctl[3].active);
  endproperty
  a_inputs_idle: assert property (p_inputs_idle) else $error("input active outside slot");

  property p_hold_cfg;
    @(posedge clk) disable iff (reset)
    (state_r != ST_IDLE) |=> $stable(cur_r) && $stable(grant_r);
  endproperty
  a_hold_cfg: assert property (p_hold_cfg) else $error("slot settings changed mid-slot");

  property p_wrap;
    @(posedge clk) disable iff (reset)
    s_slot_last |=> slot_r == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("slot walk did not wrap");
endmodule

// ==== afesl_pkg.sv ====
// constants, types and register layout for the slot control block
package afesl_pkg;
  localparam int NUM_SLOTS = 12;
  localparam int NUM_PAIRS = 4;
  localparam int NUM_DRV   = 4;
  localparam int LEVEL_W   = 7;
  localparam int CLK_PERIOD_NS = 20;
  localparam int NS_PER_US     = 1000;
  localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
  localparam logic [11:0] ADDR_GLOBAL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS    = 12'h004;
  localparam logic [11:0] ADDR_SLOT_BASE = 12'h100;
  localparam logic [11:0] ADDR_SLOT_END  = 12'h1C0;
  localparam int SLOT_SHIFT = 4;
  localparam int SLOT_WORDS = 3;
  localparam int G_RUN_BIT  = 0;
  localparam int G_DIFF_LSB = 4;
  localparam int G_IDLE_LSB = 8;
  localparam int W0_ROUTE_LSB  = 0;
  localparam int W0_PRECON_LSB = 16;
  localparam int W0_CH2_BIT    = 19;
  localparam int W0_MODE_LSB   = 20;
  localparam int W0_SLOTEN_BIT = 22;
  localparam int W0_PREW_LSB   = 24;
  localparam int W2_SIDE_LSB   = 0;
  localparam int W2_PULSEW_LSB = 8;
  localparam logic [7:0]  PRE_WIDTH_US_RST   = 8'h08;
  localparam logic [7:0]  PULSE_WIDTH_US_RST = 8'h04;
  localparam logic [31:0] W0_RST = {PRE_WIDTH_US_RST, 24'h00_0000};
  localparam logic [31:0] W2_RST = {16'h0000, PULSE_WIDTH_US_RST, 8'h00};
  localparam logic [8:0]  TOTAL_LIMIT_MA = 9'h190;
  localparam logic [8:0]  DRIVER_MAX_MA  = 9'h0C8;
  localparam logic [6:0]  STEP_KNEE      = 7'h10;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_PRE   = 3'h1,
    ST_PULSE = 3'h3,
    ST_CONV1 = 3'h2,
    ST_CONV2 = 3'h6,
    ST_WR1   = 3'h7,
    ST_WR2   = 3'h5,
    ST_NEXT  = 3'h4
  } afesl_state_e;

  typedef enum logic [1:0] {
    MODE_STANDARD = 2'h0,
    MODE_DIGINT   = 2'h1,
    MODE_IMPULSE  = 2'h2,
    MODE_RSVD     = 2'h3
  } afesl_mode_e;

  typedef enum logic [2:0] {
    PRE_FLOAT   = 3'h0,
    PRE_BIAS1   = 3'h1,
    PRE_BIAS2   = 3'h2,
    PRE_ICM     = 3'h3,
    PRE_AMP_REF = 3'h4,
    PRE_AMP_IN  = 3'h5,
    PRE_SHORT   = 3'h6
  } afesl_precon_e;

  typedef struct packed {
    logic [3:0][3:0] route;
    logic [2:0]      precon;
    logic            ch2_en;
    afesl_mode_e     mode;
    logic            slot_en;
    logic [7:0]      pre_w;
    logic [3:0]      sides;
    logic [7:0]      pulse_w;
    logic [3:0][6:0] level;
  } afesl_slot_s;

  typedef struct packed {
    logic       active;
    logic       diff;
    logic [3:0] route;
    logic [1:0] idle;
  } afesl_pair_s;

  typedef struct packed {
    logic [3:0]      side_a_en;
    logic [3:0]      side_b_en;
    logic [3:0][7:0] grant_ma;
  } afesl_led_s;
endpackage

// ==== afesl_adc_model.sv ====
// converter partner: answers each start with a one-cycle done after a delay
module afesl_adc_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic adc_start,
  input  wire logic slow,
  output logic      adc_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial adc_done = 1'b0;
  // done never overlaps start, as a real converter needs time
  always @(posedge clk)
  begin
    adc_done <= 1'b0;
    if (reset)
      cnt <= 0;
    else if (adc_start)
      cnt <= slow ? 40 : 3;
    else if (cnt == 1)
    begin
      cnt <= 0;
      adc_done <= 1'b1;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule

// ==== afesl_ctrl_bench.sv ====
// self-checking bench for the slot sequencer, routing and led control
module afesl_ctrl_bench;
  import afesl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1, slow = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic adc_done, adc_start, adc_chan, buf_wr, buf_chan, ch2_power, precon_active;
  logic [3:0] slot_index;
  afesl_precon_e precon_sel;
  afesl_pair_s [3:0] pair_ctl;
  afesl_led_s led_ctl;
  int n_errors = 0;
  int total_checks = 0;
  int seed = 32'h113f68e5;
  int ev[$];

  afesl_ctrl u_afesl_ctrl (.clk, .reset, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .adc_done, .adc_start, .adc_chan, .buf_wr, .buf_chan,
    .slot_index, .ch2_power, .precon_active, .precon_sel, .pair_ctl, .led_ctl);
  afesl_adc_model u_afesl_adc_model (.clk, .reset, .adc_start, .slow, .adc_done);

  always #10 clk = ~clk;

  // log of conversions (chan) and buffer writes (2 + chan) in order
  always @(posedge clk)
  begin
    if (!reset && adc_start === 1'b1)
      ev.push_back(int'(adc_chan));
    if (!reset && buf_wr === 1'b1)
      ev.push_back(2 + int'(buf_chan));
  end

  task automatic report_and_stop;
    begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      total_checks++;
      if (got !== exp)
      begin
        n_errors++;
        $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    begin
      t = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge clk);
        t++;
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1 && t < 200);
      if (t >= 200) n_errors++;
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    begin
      t = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge clk);
        t++;
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1 && t < 200);
      if (t >= 200) n_errors++;
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask

  function automatic int ma(input int c);
    if (c == 0)
      return 0;
    if (c < 16)
      return c + 1;
    return (16 + 2 * (c - 15) > 200) ? 200 : 16 + 2 * (c - 15);
  endfunction

  // slow converter runs keep the whole run to a few thousand cycles, far below the 50k-cycle limit
  initial
  begin
    #1000000;
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    logic [1:0] r;
    logic [31:0] d;
    int t, rem, g, dm, idl;
    int rt[2][4], lv[2][4], sd[2], pc[2], c2[2], md[2], pw[2], ex[$];
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("ch2_power", 0, ch2_power);
    check("led_a", 0, led_ctl.side_a_en);
    check("slot_index", 0, slot_index);
    axi_read(ADDR_SLOT_BASE, d, r);
    check("w0_rst", W0_RST, d);
    axi_read(ADDR_SLOT_BASE + 12'h008, d, r);
    check("w2_rst", W2_RST, d);
    axi_read(12'h800, d, r);
    check("rd_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_write(12'h800, 32'h1, r);
    check("wr_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_write(ADDR_STATUS, 32'hFFFF_FFFF, r);
    check("st_resp", {30'h0, RESP_OKAY}, {30'h0, r});
    for (int k = 0; k < 7; k++)
    begin
      dm = $random(seed) & 15;
      idl = $random(seed) & 255;
      slow <= k[0];
      for (int s = 0; s < 2; s++)
      begin
        for (int i = 0; i < 4; i++)
        begin
          rt[s][i] = $random(seed) & 15;
          lv[s][i] = $random(seed) & 127;
        end
        // over the total limit on purpose
        if (k == 0)
          lv[s] = '{127, 127, 127, 127};
        if (k == 1)
          lv[s] = '{15, 16, 0, 1};
        sd[s] = $random(seed) & 15;
        pc[s] = (k + 3 * s) % 7;
        c2[s] = (s == 0) ? ($random(seed) & 1) : 1;
        md[s] = (s == 0) ? 0 : 1 + k % 2;
        pw[s] = 1 + k % 2;
        axi_write(ADDR_SLOT_BASE + 12'(s * 16), {8'(pw[s]), 2'b01, 2'(md[s]), 1'(c2[s]),
          3'(pc[s]), 4'(rt[s][3]), 4'(rt[s][2]), 4'(rt[s][1]), 4'(rt[s][0])}, r);
        axi_write(ADDR_SLOT_BASE + 12'(s * 16 + 4), {1'b0, 7'(lv[s][3]), 1'b0, 7'(lv[s][2]),
          1'b0, 7'(lv[s][1]), 1'b0, 7'(lv[s][0])}, r);
        axi_write(ADDR_SLOT_BASE + 12'(s * 16 + 8), {16'h0, 8'h02, 4'h0, 4'(sd[s])}, r);
      end
      axi_write(ADDR_GLOBAL, {16'h0, 8'(idl), 4'(dm), 4'h1}, r);
      for (int s = 0; s < 2; s++)
      begin
        t = 0;
        while (precon_active !== 1'b1 && t < 3000)
        begin
          @(posedge clk);
          t++;
        end
        if (t >= 3000) n_errors++;
        check("slot_index", s, slot_index);
        check("precon_sel", pc[s], precon_sel);
        for (int i = 0; i < 4; i++)
          check("pair", {rt[s][i] != 0, dm[i], 4'(rt[s][i]), idl[2*i+:2]}, pair_ctl[i]);
        t = 0;
        // clock enable pause in slot 0 must stretch precondition by ten cycles
        while (precon_active === 1'b1 && t < 500)
        begin
          if (s == 0 && t == 5) ce <= 1'b0;
          if (s == 0 && t == 15) ce <= 1'b1;
          @(posedge clk);
          t++;
        end
        check("pre_len", pw[s] * CYC_PER_US + ((s == 0) ? 10 : 0), t);
        rem = 400;
        for (int i = 0; i < 4; i++)
        begin
          g = (ma(lv[s][i]) < rem) ? ma(lv[s][i]) : rem;
          rem -= g;
          check("grant", g, led_ctl.grant_ma[i]);
          check("both", 0, led_ctl.side_a_en[i] & led_ctl.side_b_en[i]);
          if (g != 0)
            check("sides", {~sd[s][i], sd[s][i]}, {led_ctl.side_a_en[i], led_ctl.side_b_en[i]});
        end
        check("ch2_power", (md[s] == 0) ? c2[s] : 0, ch2_power);
        if (s == 1)
          axi_write(ADDR_GLOBAL, {16'h0, 8'(idl), 4'(dm), 4'h0}, r);
      end
      if (c2[0])
        ex = '{0, 1, 2, 3, 0, 2};
      else
        ex = '{0, 2, 0, 2};
      t = 0;
      while (ev.size() < ex.size() && t < 3000)
      begin
        @(posedge clk);
        t++;
      end
      repeat (8) @(posedge clk);
      check("n_events", ex.size(), ev.size());
      for (int i = 0; i < ex.size() && i < ev.size(); i++)
        check("event", ex[i], ev[i]);
      for (int i = 0; i < 4; i++)
        check("idle_active", 0, pair_ctl[i].active);
      check("stop_index", 2, slot_index);
      ev.delete();
    end
    report_and_stop();
  end
endmodule
